// file: bench/cms_pulse_src.sv
// partner: external pulse source such as an encoder, driving the pulse pins
`timescale 1ns/1ps
module cms_pulse_src (
  input wire logic aclk, // clock
  output logic phase_a, // pulse phase A
  output logic phase_b, // pulse phase B
  output logic func_in // function input level
);
  // pins idle low, as a released open encoder output would read here
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    func_in = 1'b0;
  end
  ////////////////////////////////////////
  // n pulses on phase A, h cycles high then h cycles low
  task automatic burst(input int n, input int h);
    repeat (n) begin
      @(posedge aclk);
      phase_a <= 1'b1;
      repeat (h) @(posedge aclk);
      phase_a <= 1'b0;
      repeat (h - 1) @(posedge aclk);
    end
  endtask
  // n pulses on phase B while phase A rests
  task automatic burst_b(input int n, input int h);
    repeat (n) begin
      @(posedge aclk);
      phase_b <= 1'b1;
      repeat (h) @(posedge aclk);
      phase_b <= 1'b0;
      repeat (h - 1) @(posedge aclk);
    end
  endtask
  // one high level of c cycles on the function input
  task automatic width(input int c);
    @(posedge aclk);
    func_in <= 1'b1;
    repeat (c) @(posedge aclk);
    func_in <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
endmodule

// file: bench/counter_mode_and_source_select_test.sv
// bench: scenarios for the channel's mode and count source selection
`timescale 1ns/1ps
module counter_mode_and_source_select_test;
  import cms_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, phase_a, phase_b, func_in;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  cms_peer_type peer_i, peer_o;
  int error_cnt = 0;
  int tests_run = 0;
  cms_channel DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .phase_a(phase_a), .phase_b(phase_b),
    .func_in(func_in), .peer_i(peer_i), .peer_o(peer_o));
  cms_pulse_src src (.aclk(aclk), .phase_a(phase_a), .phase_b(phase_b), .func_in(func_in));
  ////////////////////////////////////////
  // range compare; an unknown never lands inside the range
  task automatic chk(input string nm, input logic [31:0] lo, hi, got);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  // one write; address and data offered together, each dropped when taken;
  // handshakes are judged at the falling edge, where the outputs have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit done = 0;
    bit aw_t, w_t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      aw_t = awvalid && (awready === 1'b1);
      w_t = wvalid && (wready === 1'b1);
      done = (bvalid === 1'b1);
      if (done) wr_r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
    chk("write answer", 1, 1, {31'h0, done});
  endtask
  // one read into rd_d and rd_r
  task automatic rd(input logic [7:0] a);
    bit done = 0;
    bit ar_t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      ar_t = arvalid && (arready === 1'b1);
      done = (rvalid === 1'b1);
      if (done) begin
        rd_d = rdata;
        rd_r = rresp;
      end
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    chk("read answer", 1, 1, {31'h0, done});
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m, lo, hi);
    rd(a);
    chk(nm, lo, hi, rd_d & m);
  endtask
  // n rising edges on the peer flag (f=1) or peer output (f=0)
  task automatic pp(input int n, input bit f);
    repeat (n) begin
      @(posedge aclk);
      if (f) peer_i.flag <= 1'b1;
      else peer_i.out <= 1'b1;
      repeat (2) @(posedge aclk);
      peer_i.flag <= 1'b0;
      peer_i.out <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask
  ////////////////////////////////////////
  // reset values, unmapped access, mode codes, pulse input mode gating
  task automatic t_regs();
    rd_chk("preset", ADDR_PRESET, '1, PRESET_RST, PRESET_RST);
    rd_chk("unit", ADDR_UNIT, '1, UNIT_RST, UNIT_RST);
    rd_chk("ppr", ADDR_PPR, '1, PPR_RST, PPR_RST);
    rd_chk("period", ADDR_PERIOD, '1, PERIOD_RST, PERIOD_RST);
    rd_chk("duty", ADDR_DUTY, '1, DUTY_RST, DUTY_RST);
    rd_chk("status flag", ADDR_STATUS, 32'h1, 1, 1);
    @(negedge aclk);
    chk("peer flag", 1, 1, {31'h0, peer_o.flag});
    chk("peer mode", MODE_NORMAL, MODE_NORMAL, {29'h0, peer_o.mode});
    rd(8'h24);
    chk("unmapped resp", RESP_SLVERR, RESP_SLVERR, {30'h0, rd_r});
    wr(8'h24, 32'h0);
    chk("unmapped write resp", RESP_SLVERR, RESP_SLVERR, {30'h0, wr_r});
    for (int m = 0; m < 5; m++) begin
      wr(ADDR_CTRL, m);
      rd_chk("mode", ADDR_CTRL, 32'h7, m, m);
    end
    wr(ADDR_CTRL, 32'h0000_0007);
    chk("write resp", RESP_OKAY, RESP_OKAY, {30'h0, wr_r});
    rd_chk("mode kept", ADDR_CTRL, 32'h7, 4, 4);
    wr(ADDR_CTRL, 32'h0000_0510);
    rd_chk("pim refused", ADDR_CTRL, 32'h7ff, 32'h10, 32'h10);
    wr(ADDR_CTRL, 32'h0000_0500);
    rd_chk("pim taken", ADDR_CTRL, 32'h7ff, 32'h500, 32'h500);
  endtask
  // phase A counting up, then down by command
  task automatic t_ab();
    wr(ADDR_CTRL, 32'h0001_0000);
    src.burst(5, 4);
    rd_chk("count up", ADDR_COUNT, '1, 5, 5);
    wr(ADDR_CTRL, 32'h0000_2000);
    src.burst(3, 4);
    rd_chk("count down", ADDR_COUNT, '1, 2, 2);
    wr(ADDR_CTRL, 32'h0001_0200);
    src.burst(3, 4);
    rd_chk("count x2", ADDR_COUNT, '1, 6, 6);
    wr(ADDR_CTRL, 32'h0001_0400);
    src.burst(3, 4);
    src.burst_b(1, 4);
    rd_chk("count cw", ADDR_COUNT, '1, 2, 2);
  endtask
  // each internal clock, on-delay output, refusal outside normal mode
  task automatic t_int();
    int per = TICK_BASE_CYC;
    for (int s = 1; s < 5; s++) begin
      wr(ADDR_CTRL, 32'h0001_0000 | (s << 4));
      repeat (2 * per) @(posedge aclk);
      rd_chk("tick count", ADDR_COUNT, '1, 1, 3);
      per = per * DECADE;
    end
    wr(ADDR_PRESET, 8);
    wr(ADDR_CTRL, 32'h0001_0010);
    rd_chk("delay off", ADDR_STATUS, 32'h2, 0, 0);
    repeat (9 * TICK_BASE_CYC) @(posedge aclk);
    rd_chk("delay on", ADDR_STATUS, 32'h2, 2, 2);
    chk("peer out", 1, 1, {31'h0, peer_o.out});
    wr(ADDR_CTRL, 32'h0001_0011);
    repeat (100) @(posedge aclk);
    rd_chk("refused count", ADDR_COUNT, '1, 0, 0);
    rd_chk("refused flag", ADDR_STATUS, 32'h4, 4, 4);
  endtask
  // other channel as source in its normal, pwm and a refused mode
  task automatic t_other();
    wr(ADDR_CTRL, 32'h0001_0050);
    pp(3, 1);
    pp(2, 0);
    rd_chk("peer flag", ADDR_COUNT, '1, 3, 3);
    peer_i.mode <= MODE_PWM;
    wr(ADDR_CTRL, 32'h0001_0050);
    pp(2, 0);
    rd_chk("peer out", ADDR_COUNT, '1, 2, 2);
    peer_i.mode <= MODE_FREQ;
    wr(ADDR_CTRL, 32'h0001_0050);
    pp(2, 0);
    pp(2, 1);
    rd_chk("peer refused", ADDR_COUNT, '1, 0, 0);
    rd_chk("peer status", ADDR_STATUS, 32'h4, 4, 4);
    peer_i.mode <= MODE_NORMAL;
  endtask
  // pwm high time over two periods, then zero duty
  task automatic t_pwm();
    int hi = 0;
    wr(ADDR_CTRL, 32'h0000_0004);
    repeat (500) begin
      @(negedge aclk);
      hi += (peer_o.out === 1'b1);
    end
    chk("pwm high", 249, 251, hi);
    wr(ADDR_DUTY, 0);
    repeat (260) @(posedge aclk);
    hi = 0;
    repeat (500) begin
      @(negedge aclk);
      hi += (peer_o.out === 1'b1);
    end
    chk("pwm zero", 0, 0, hi);
  endtask
  // frequency, rotation speed and width measurement
  task automatic t_meas();
    wr(ADDR_UNIT, 10);
    wr(ADDR_CTRL, 32'h0001_0001);
    src.burst(60, 50);
    rd_chk("freq", ADDR_MEAS, '1, 24, 26);
    wr(ADDR_PPR, 5);
    wr(ADDR_CTRL, 32'h0001_0002);
    src.burst(60, 50);
    rd_chk("speed", ADDR_MEAS, '1, 4, 6);
    wr(ADDR_CTRL, 32'h0001_1003);
    src.width(10 * TICK_BASE_CYC);
    rd_chk("width", ADDR_MEAS, '1, 9, 11);
  endtask
  ////////////////////////////////////////
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // 4 ns clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // watchdog: the whole run needs about 70000 cycles
  initial begin
    repeat (100000) @(posedge aclk);
    error_cnt++;
    complete_run();
  end
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    peer_i = '{MODE_NORMAL, 1'b0, 1'b0};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_ab();
    t_int();
    t_other();
    t_pwm();
    t_meas();
    complete_run();
  end
endmodule

// file: rtl/cms_channel.sv
// channel: operation mode and count source selection with axi4-lite registers
`timescale 1ns/1ps
module cms_channel (
  input wire logic aclk, // clock, 250 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [7:0] awaddr, // write byte address
  input wire logic [2:0] awprot, // unused protection
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [7:0] araddr, // read byte address
  input wire logic [2:0] arprot, // unused protection
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  input wire logic phase_a, // pulse input phase A
  input wire logic phase_b, // pulse input phase B
  input wire logic func_in, // function input for width measuring
  input wire cms_pkg::cms_peer_type peer_i, // other channel's view
  output cms_pkg::cms_peer_type peer_o // this channel's view for the other
);
  import cms_pkg::*;

  cms_state_type s_q, s_d; // all state and its next value
  logic [N_TICKS-1:0] tick; // internal clock pulses
  logic legal; // chosen source allowed in this mode
  logic [1:0] ev; // {down, up} count events of the source
  logic [1:0] ab; // {down, up} events of the A/B decoder
  logic osel; // selected signal of the other channel
  logic wr_fire; // write performed this cycle
  logic [31:0] wnew; // strobed write value
  logic [31:0] ctrl_rd; // control register as read
  logic act; // function input at measured level
  logic win_end; // measuring window closes

  ////////////////////////////////////////////////////////////////////////////
  // internal clocks
  cms_tick u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pulse input decoder, returns {down, up}
  function automatic logic [1:0] pdec(input cms_pim_type m, input logic a, b, pa, pb, dn);
    logic ar, af, br, bf, d;
    ar = a & ~pa;
    af = ~a & pa;
    br = b & ~pb;
    bf = ~b & pb;
    d = b | dn; // phase B doubles as down command
    unique case (m)
      PIM_1X1: pdec = d ? {af, 1'b0} : {1'b0, ar};
      PIM_1X1A: pdec = dn ? {af, 1'b0} : {1'b0, ar};
      PIM_1X2: pdec = d ? {ar | af, 1'b0} : {1'b0, ar | af};
      PIM_1X2A: pdec = dn ? {ar | af, 1'b0} : {1'b0, ar | af};
      PIM_CW: pdec = {br & ~a, ar & ~b};
      PIM_2X1: pdec = {af & ~b, ar & ~b};
      PIM_2X2: pdec = {(ar & b) | (af & ~b), (ar & ~b) | (af & b)};
      PIM_2X4: pdec = {(ar & b) | (af & ~b) | (br & ~a) | (bf & a),
                       (ar & ~b) | (af & b) | (br & a) | (bf & ~a)};
    endcase
  endfunction

  // source legality, also watched by the checks below
  function automatic logic src_ok(input cms_mode_type m, input cms_src_type s,
                                  input cms_mode_type om);
    unique case (s)
      SRC_AB: src_ok = 1'b1;
      SRC_IC01, SRC_IC1, SRC_IC10, SRC_IC100: src_ok = (m == MODE_NORMAL);
      SRC_OTHER: src_ok = (m == MODE_NORMAL) &&
                          (om == MODE_NORMAL || om == MODE_PWM);
      default: src_ok = 1'b0;
    endcase
  endfunction

  // byte strobe merge
  function automatic logic [31:0] wmerge(input logic [31:0] o, n, input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      wmerge[8*i +: 8] = st[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // source selection
  always_comb begin
    ab = pdec(s_q.pim, phase_a, phase_b, s_q.pa, s_q.pb, s_q.down);
    // pwm partner counts on its output, normal partner on its flag
    osel = (peer_i.mode == MODE_PWM) ? peer_i.out : peer_i.flag;
    legal = src_ok(s_q.mode, s_q.src, peer_i.mode);
    unique case (s_q.src)
      SRC_AB: ev = ab;
      SRC_IC01: ev = {1'b0, tick[0]};
      SRC_IC1: ev = {1'b0, tick[1]};
      SRC_IC10: ev = {1'b0, tick[2]};
      SRC_IC100: ev = {1'b0, tick[3]};
      SRC_OTHER: ev = {1'b0, osel & ~s_q.po};
      default: ev = 2'b00;
    endcase
    if (!legal) begin
      ev = 2'b00; // refused combination does not count
    end
  end

  // helpers for the datapath and the bus
  assign act = (func_in == s_q.level);
  assign win_end = tick[TICK_1US] && (s_q.win >= s_q.unit - 32'h1);
  assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign wnew = wmerge(ctrl_rd, s_q.wdata, s_q.wstrb);
  assign ctrl_rd = {16'h0000, 2'b00, s_q.down, s_q.level, 1'b0, s_q.pim,
                    1'b0, s_q.src, 1'b0, s_q.mode};

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    s_d.pa = phase_a;
    s_d.pb = phase_b;
    s_d.pf = func_in;
    s_d.po = osel;
    // per-mode datapath
    unique case (s_q.mode)
      MODE_NORMAL: begin
        // general counter, up or down per source
        if (ev[0]) begin
          s_d.cnt = s_q.cnt + 32'h1;
        end else if (ev[1]) begin
          s_d.cnt = s_q.cnt - 32'h1;
        end
      end
      MODE_FREQ: begin
        // pulses per window, windows in 1 us steps
        s_d.acc = s_q.acc + 32'(ab[0] | ab[1]);
        if (tick[TICK_1US]) begin
          s_d.win = s_q.win + 32'h1;
        end
        if (win_end) begin
          s_d.meas = s_d.acc;
          s_d.acc = '0;
          s_d.win = '0;
        end
      end
      MODE_SPEED: begin
        // whole rotations per window; partial rotations carry over
        if (ab[0] | ab[1]) begin
          if (s_q.pcnt >= s_q.ppr - 32'h1) begin
            s_d.pcnt = '0;
            s_d.rev = s_q.rev + 32'h1;
          end else begin
            s_d.pcnt = s_q.pcnt + 32'h1;
          end
        end
        if (tick[TICK_1US]) begin
          s_d.win = s_q.win + 32'h1;
        end
        if (win_end) begin
          s_d.meas = s_d.rev;
          s_d.rev = '0;
          s_d.win = '0;
        end
      end
      MODE_PULSE: begin
        // width in 0.1 us steps, stored when the level ends
        if (act && tick[0]) begin
          s_d.acc = s_q.acc + 32'h1;
        end
        if (!act && (s_q.pf == s_q.level)) begin
          s_d.meas = s_q.acc;
          s_d.acc = '0;
        end
      end
      MODE_PWM: begin
        // period and on time in 0.1 us steps
        if (tick[0]) begin
          s_d.pcnt = (s_q.pcnt >= s_q.period - 32'h1) ? '0 : s_q.pcnt + 32'h1;
        end
        s_d.coin_out = (s_d.pcnt < s_q.duty);
      end
    endcase

    // write channel: address and data taken in either order
    if (awvalid && awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      unique case (s_q.awaddr)
        ADDR_CTRL: begin
          // codes past the last mode are ignored
          if (wnew[CTRL_MODE_LSB +: 3] <= MODE_LAST) begin
            s_d.mode = cms_mode_type'(wnew[CTRL_MODE_LSB +: 3]);
          end
          if (wnew[CTRL_SRC_LSB +: 3] <= SRC_LAST) begin
            s_d.src = cms_src_type'(wnew[CTRL_SRC_LSB +: 3]);
          end
          if (wnew[CTRL_SRC_LSB +: 3] == SRC_AB) begin
            s_d.pim = cms_pim_type'(wnew[CTRL_PIM_LSB +: 3]);
          end
          s_d.level = wnew[CTRL_LEVEL_BIT];
          s_d.down = wnew[CTRL_DOWN_BIT];
          // a new setting restarts the measurements
          s_d.acc = '0;
          s_d.win = '0;
          s_d.pcnt = '0;
          s_d.rev = '0;
          if (s_q.wstrb[CTRL_CLR_BIT / 8] && s_q.wdata[CTRL_CLR_BIT]) begin
            s_d.cnt = '0;
          end
        end
        ADDR_PRESET: s_d.preset = wmerge(s_q.preset, s_q.wdata, s_q.wstrb);
        ADDR_UNIT: s_d.unit = wmerge(s_q.unit, s_q.wdata, s_q.wstrb);
        ADDR_PPR: s_d.ppr = wmerge(s_q.ppr, s_q.wdata, s_q.wstrb);
        ADDR_PERIOD: s_d.period = wmerge(s_q.period, s_q.wdata, s_q.wstrb);
        ADDR_DUTY: s_d.duty = wmerge(s_q.duty, s_q.wdata, s_q.wstrb);
        ADDR_COUNT, ADDR_MEAS, ADDR_STATUS: s_d.bresp = RESP_OKAY; // read only
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end

    // read channel: data registered with the answer
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      unique case (araddr)
        ADDR_CTRL: s_d.rdata = ctrl_rd;
        ADDR_PRESET: s_d.rdata = s_q.preset;
        ADDR_UNIT: s_d.rdata = s_q.unit;
        ADDR_PPR: s_d.rdata = s_q.ppr;
        ADDR_PERIOD: s_d.rdata = s_q.period;
        ADDR_DUTY: s_d.rdata = s_q.duty;
        ADDR_COUNT: s_d.rdata = s_q.cnt;
        ADDR_MEAS: s_d.rdata = s_q.meas;
        ADDR_STATUS: begin
          s_d.rdata = '0;
          s_d.rdata[STAT_FLAG_BIT] = s_q.flag;
          s_d.rdata[STAT_OUT_BIT] = s_q.coin_out;
          s_d.rdata[STAT_ERR_BIT] = ~legal;
        end
        default: begin
          s_d.rdata = '0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end

    // flag and on-delay output follow the final count and preset, so a change into normal
    // mode or a preset write never leaves the output one cycle stale
    s_d.flag = (s_d.mode == MODE_NORMAL) && (s_d.cnt == s_d.preset);
    if (s_d.mode == MODE_NORMAL) begin
      s_d.coin_out = (s_d.cnt >= s_d.preset);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.preset <= PRESET_RST;
      s_q.unit <= UNIT_RST;
      s_q.ppr <= PPR_RST;
      s_q.period <= PERIOD_RST;
      s_q.duty <= DUTY_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign awready = !s_q.aw_got && !s_q.bvalid;
  assign wready = !s_q.w_got && !s_q.bvalid;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = !s_q.rvalid;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign peer_o = '{mode: s_q.mode, flag: s_q.flag, out: s_q.coin_out};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic ctrl_wr; // control write under way
  assign ctrl_wr = wr_fire && (s_q.awaddr == ADDR_CTRL);

  sequence s_other_rise;
    s_q.mode == MODE_NORMAL && s_q.src == SRC_OTHER && legal && osel && !s_q.po;
  endsequence

  property p_refused_hold;
    s_q.mode == MODE_NORMAL && !src_ok(s_q.mode, s_q.src, peer_i.mode) && !wr_fire
      |=> $stable(s_q.cnt);
  endproperty
  a_refused_hold: assert property (p_refused_hold)
    else $error("counter moved on a refused source");

  property p_ic_step;
    s_q.mode == MODE_NORMAL && s_q.src == SRC_IC01 && tick[0] && !wr_fire
      |=> s_q.cnt == $past(s_q.cnt) + 32'h1;
  endproperty
  a_ic_step: assert property (p_ic_step)
    else $error("internal clock tick not counted");

  property p_tick_gap;
    tick[0] |=> !tick[0] [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("finest internal clock too fast");

  property p_on_delay;
    $past(aresetn) && s_q.mode == MODE_NORMAL && $stable(s_q.preset) && s_q.cnt >= s_q.preset
      |-> s_q.coin_out;
  endproperty
  a_on_delay: assert property (p_on_delay)
    else $error("coincidence output off after preset");

  property p_other;
    s_other_rise and !wr_fire |=> s_q.cnt == $past(s_q.cnt) + 32'h1;
  endproperty
  a_other: assert property (p_other)
    else $error("other channel rise not counted");

  property p_pwm_off;
    s_q.mode == MODE_PWM && $stable(s_q.duty) && $stable(s_q.mode)
      && s_q.pcnt >= s_q.duty |-> !s_q.coin_out;
  endproperty
  a_pwm_off: assert property (p_pwm_off)
    else $error("pwm output on past duty");

  property p_pim_guard;
    ctrl_wr && wnew[CTRL_SRC_LSB +: 3] != SRC_AB |=> $stable(s_q.pim);
  endproperty
  a_pim_guard: assert property (p_pim_guard)
    else $error("pulse input mode changed without A/B");

  property p_width;
    s_q.mode == MODE_PULSE && !act && s_q.pf == s_q.level && !wr_fire
      |=> s_q.meas == $past(s_q.acc);
  endproperty
  a_width: assert property (p_width)
    else $error("pulse width not stored");

endmodule

// file: rtl/cms_pkg.sv
// package: constants, enums and carriers of the counter mode and source block
package cms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_PS = 4000; // aclk at 250 MHz
  localparam int TICK_BASE_PS = 100000; // finest internal clock, 0.1 us
  // least time rounds up to whole cycles
  localparam int TICK_BASE_CYC = (TICK_BASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int N_TICKS = 4; // 0.1, 1, 10 and 100 us
  localparam int DECADE = 10; // ratio between neighbouring internal clocks
  localparam int TICK_1US = 1; // index of the 1 us tick

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00; // mode, source, pulse input mode
  localparam logic [7:0] ADDR_PRESET = 8'h04; // coincidence value no.1
  localparam logic [7:0] ADDR_UNIT = 8'h08; // measuring window, 1 us units
  localparam logic [7:0] ADDR_PPR = 8'h0c; // pulses per rotation
  localparam logic [7:0] ADDR_PERIOD = 8'h10; // pwm period, 0.1 us units
  localparam logic [7:0] ADDR_DUTY = 8'h14; // pwm on time, 0.1 us units
  localparam logic [7:0] ADDR_COUNT = 8'h18; // counter value, read only
  localparam logic [7:0] ADDR_MEAS = 8'h1c; // measured value, read only
  localparam logic [7:0] ADDR_STATUS = 8'h20; // status, read only

  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SRC_LSB = 4;
  localparam int CTRL_PIM_LSB = 8;
  localparam int CTRL_LEVEL_BIT = 12; // 1: measure on width, 0: off width
  localparam int CTRL_DOWN_BIT = 13; // count down command
  localparam int CTRL_CLR_BIT = 16; // write 1 clears the counter
  // status bit positions
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_OUT_BIT = 1;
  localparam int STAT_ERR_BIT = 2;

  // reset values
  localparam logic [31:0] PRESET_RST = 32'h0000_0000;
  localparam logic [31:0] UNIT_RST = 32'h0000_03e8;
  localparam logic [31:0] PPR_RST = 32'h0000_0001;
  localparam logic [31:0] PERIOD_RST = 32'h0000_000a;
  localparam logic [31:0] DUTY_RST = 32'h0000_0005;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // enumerations
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_FREQ = 3'b001,
    MODE_SPEED = 3'b010,
    MODE_PULSE = 3'b011,
    MODE_PWM = 3'b100
  } cms_mode_type;
  localparam logic [2:0] MODE_LAST = 3'b100; // codes above are refused

  typedef enum logic [2:0] {
    SRC_AB = 3'b000,
    SRC_IC01 = 3'b001,
    SRC_IC1 = 3'b010,
    SRC_IC10 = 3'b011,
    SRC_IC100 = 3'b100,
    SRC_OTHER = 3'b101
  } cms_src_type;
  localparam logic [2:0] SRC_LAST = 3'b101;

  typedef enum logic [2:0] {
    PIM_1X1 = 3'b000,
    PIM_1X1A = 3'b001,
    PIM_1X2 = 3'b010,
    PIM_1X2A = 3'b011,
    PIM_CW = 3'b100,
    PIM_2X1 = 3'b101,
    PIM_2X2 = 3'b110,
    PIM_2X4 = 3'b111
  } cms_pim_type;

  // what one channel shows the other one
  typedef struct packed {
    cms_mode_type mode; // operation mode
    logic flag; // counter value coincidence no.1
    logic out; // coincidence output no.1
  } cms_peer_type;

  // whole state of the channel
  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    cms_mode_type mode;
    cms_src_type src;
    cms_pim_type pim;
    logic level;
    logic down;
    logic [31:0] preset, unit, ppr, period, duty;
    logic [31:0] cnt, meas, win, acc, pcnt, rev;
    logic pa, pb, pf, po;
    logic flag;
    logic coin_out;
  } cms_state_type;

endpackage

// file: rtl/cms_tick.sv
// tick: decade divider giving the internal clock pulses from aclk
`timescale 1ns/1ps
module cms_tick #(
  parameter int BASE_CYC = cms_pkg::TICK_BASE_CYC, // aclk cycles per finest tick
  parameter int N = cms_pkg::N_TICKS // number of internal clocks
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // synchronous reset, active low
  output logic [N-1:0] tick // one-cycle pulse per period of each clock
);
  import cms_pkg::*;

  // refuse what the 8-bit prescaler and the decade chain cannot serve
  if (BASE_CYC < 1 || BASE_CYC > 256 || N < 2) begin : g_bad
    $error("cms_tick: unsupported parameters");
  end

  typedef struct packed {
    logic [7:0] base; // prescaler
    logic [N-2:0][3:0] dec; // one decade per slower clock
  } cms_tick_state_type;

  cms_tick_state_type s_q, s_d; // state and its next value
  logic [N-1:0] carry; // end of each period

  ////////////////////////////////////////////////////////////////////////////
  // carry chain: a slower tick fires only on the tenth faster one
  assign carry[0] = (s_q.base == 8'(BASE_CYC - 1));
  for (genvar i = 1; i < N; i++) begin : g_carry
    assign carry[i] = carry[i-1] && (s_q.dec[i-1] == 4'(DECADE - 1));
  end
  assign tick = carry;

  // next state
  always_comb begin
    s_d = s_q;
    s_d.base = carry[0] ? 8'h00 : s_q.base + 8'h01;
    for (int i = 0; i < N - 1; i++) begin
      if (carry[i]) begin
        s_d.dec[i] = carry[i+1] ? 4'h0 : s_q.dec[i] + 4'h1;
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
